/* File: test_tmrx_timer.sv */
`timescale 1ns/1ps
module test_tmrx_timer;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg rd_d = 1'b0;
    reg o0_d = 1'b0;
    reg [31:0] seed = 32'hd096_859a;
    wire [15:0] rdata;
    wire trig_pin, event_pin, o0, o1, pm, sm;
    logic [15:0] exp_q[$];
    int fails = 0, n_tests = 0, cyc = 0, pm_n, sm_n, hi_n, tg_n, n;
    always #2 clk_sys = ~clk_sys;
    tmrx_timer i_tmrx_timer (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .TRIG_PIN(trig_pin), .EVENT_PIN(event_pin),
        .OUT_PIN_ZERO(o0), .OUT_PIN_ONE(o1), .PERIOD_MATCH_IRQ(pm), .SECOND_MATCH_IRQ(sm));
    tmrx_pins i_tmrx_pins (.clk(clk_sys), .trig_pin(trig_pin), .event_pin(event_pin));
    function automatic [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input [15:0] seen, input [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic reg_wr(input [7:0] a, input [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input [7:0] a, input [15:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask
    task automatic zero();
        #1;
        pm_n = 0;
        sm_n = 0;
        hi_n = 0;
        tg_n = 0;
    endtask
    task automatic stats(input [15:0] p, input [15:0] s, input [15:0] h, input [15:0] t);
        #1;
        chk("period irqs", pm_n[15:0], p);
        chk("second irqs", sm_n[15:0], s);
        chk("pin one high", hi_n[15:0], h);
        chk("pin zero flips", tg_n[15:0], t);
    endtask
    // ----------------------------------------
    // output watcher: read notes and pin stats
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (rd_d)
            chk("rdata", rdata, exp_q.pop_front());
        rd_d <= rd;
        // unknown levels count as activity so they cannot hide in a zero count
        pm_n += (pm !== 1'b0);
        sm_n += (sm !== 1'b0);
        hi_n += (o1 !== 1'b0);
        tg_n += (o0 !== o0_d);
        o0_d = o0;
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(8'h18, 16'hFFFF);
        reg_rd(8'h1C, 16'h0000);
        seed = nx(seed);
        reg_wr(8'h0C, seed[15:0]);
        reg_rd(8'h0C, {12'h000, seed[3:0]});
        $display("register test done");
        reg_wr(8'h04, 16'h0001);
        reg_wr(8'h10, 16'hFFFF);
        for (int c = 0; c < 4; c++) begin
            seed = nx(seed);
            n = 1 + seed[2:0];
            reg_wr(8'h00, 16'h0000);
            reg_wr(8'h0C, {12'h000, c[1:0], 2'b00});
            reg_wr(8'h00, 16'h0001);
            i_tmrx_pins.events(n, 2 + c % 2);
            repeat (8) @(posedge clk_sys);
            reg_rd(8'h18, c == 0 ? 16'h0000 : c == 3 ? 16'(2 * n) : 16'(n));
        end
        $display("edge code test done");
        reg_wr(8'h00, 16'h0000);
        reg_wr(8'h0C, 16'h0004);
        reg_wr(8'h10, 16'h0004);
        reg_wr(8'h14, 16'h0002);
        reg_wr(8'h00, 16'h0001);
        zero();
        i_tmrx_pins.events(10, 3);
        repeat (8) @(posedge clk_sys);
        stats(16'h0002, 16'h0002, 16'h0000, 16'h0000);
        reg_wr(8'h14, 16'h0006);
        zero();
        i_tmrx_pins.events(10, 2);
        repeat (8) @(posedge clk_sys);
        stats(16'h0002, 16'h0000, 16'h0000, 16'h0000);
        $display("event count test done");
        reg_wr(8'h00, 16'h0000);
        reg_wr(8'h04, 16'h0020);
        reg_wr(8'h10, 16'h0002);
        reg_wr(8'h14, 16'h0005);
        reg_wr(8'h00, 16'h0001);
        zero();
        i_tmrx_pins.events(6, 2);
        repeat (8) @(posedge clk_sys);
        stats(16'h0002, 16'h0000, 16'h0000, 16'h0003);
        $display("event clocked interval test done");
        reg_wr(8'h00, 16'h0000);
        reg_wr(8'h10, 16'h0003);
        reg_wr(8'h14, 16'h0002);
        reg_wr(8'h0C, 16'h0001);
        reg_wr(8'h04, 16'h0002);
        reg_wr(8'h00, 16'h0001);
        reg_rd(8'h18, 16'hFFFF);
        reg_wr(8'h04, 16'h0042);
        repeat (6) @(posedge clk_sys);
        zero();
        repeat (40) @(posedge clk_sys);
        stats(16'h000A, 16'h000A, 16'h0014, 16'h000A);
        reg_wr(8'h10, 16'h0007);
        repeat (12) @(posedge clk_sys);
        zero();
        repeat (40) @(posedge clk_sys);
        stats(16'h0005, 16'h0005, 16'h000A, 16'h0005);
        reg_wr(8'h04, 16'h0042);
        $display("software trigger test done");
        reg_wr(8'h00, 16'h0000);
        repeat (8) @(posedge clk_sys);
        reg_wr(8'h00, 16'h0001);
        i_tmrx_pins.trigger();
        repeat (10) @(posedge clk_sys);
        zero();
        repeat (40) @(posedge clk_sys);
        stats(16'h0005, 16'h0005, 16'h000A, 16'h0005);
        reg_wr(8'h00, 16'h0000);
        repeat (8) @(posedge clk_sys);
        reg_rd(8'h18, 16'hFFFF);
        reg_rd(8'h04, 16'h0002);
        repeat (3) @(posedge clk_sys);
        $display("pin trigger test done");
        tally_and_finish();
    end
endmodule // test_tmrx_timer

/* File: tmrx_edge.v */
`timescale 1ns/1ps
module tmrx_edge (
    // clock and reset
    input wire CLK_SYS,
    input wire RST,
    // pin and edge choice
    input wire PIN,
    input wire [1:0] SEL,
    // detected edge
    output reg EDGE
);

`include "tmrx_map.vh"

reg sync1_q;
reg sync2_q;
reg last_q;
reg edge_d;

// ----------------------------------------
// two-flop synchroniser, then history
// ----------------------------------------
always @(posedge CLK_SYS) begin
    if (RST) begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        last_q <= 1'b0;
        EDGE <= 1'b0;
    end else begin
        sync1_q <= PIN;
        sync2_q <= sync1_q;
        last_q <= sync2_q;
        EDGE <= edge_d;
    end
end

always @* begin
    case (SEL)
        `TMRX_EDGE_RISE: edge_d = sync2_q & ~last_q;
        `TMRX_EDGE_FALL: edge_d = ~sync2_q & last_q;
        `TMRX_EDGE_BOTH: edge_d = sync2_q ^ last_q;
        default: edge_d = 1'b0;
    endcase
end

endmodule // tmrx_edge

/* File: tmrx_map.vh */
`ifndef TMRX_MAP_VH
`define TMRX_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TMRX_OFS_CTL0 8'h00
`define TMRX_OFS_CTL1 8'h04
`define TMRX_OFS_OPT0 8'h08
`define TMRX_OFS_IOC2 8'h0C
`define TMRX_OFS_CCR0 8'h10
`define TMRX_OFS_CCR1 8'h14
`define TMRX_OFS_CNT 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMRX_CTL0_CE 0
`define TMRX_CTL1_MD_HI 2
`define TMRX_CTL1_MD_LO 0
`define TMRX_CTL1_EEE 5
`define TMRX_CTL1_EST 6
`define TMRX_OPT0_OVF 0
`define TMRX_IOC2_ETS_HI 1
`define TMRX_IOC2_ETS_LO 0
`define TMRX_IOC2_EES_HI 3
`define TMRX_IOC2_EES_LO 2

// ----------------------------------------
// values
// ----------------------------------------
`define TMRX_MODE_INTERVAL 3'h0
`define TMRX_MODE_EVENT 3'h1
`define TMRX_MODE_TRIGPWM 3'h2
`define TMRX_EDGE_NONE 2'h0
`define TMRX_EDGE_RISE 2'h1
`define TMRX_EDGE_FALL 2'h2
`define TMRX_EDGE_BOTH 2'h3
`define TMRX_CNT_PRESET 16'hFFFF
`define TMRX_CNT_ZERO 16'h0000
`define TMRX_CNT_ONE 16'h0001
`define TMRX_CCR_RESET 16'h0000
`define TMRX_IOC2_RESET 4'h0
`define TMRX_DATA_ZERO 16'h0000

`endif

/* File: tmrx_pins.sv */
`timescale 1ns/1ps
module tmrx_pins (
    // clock
    input wire clk,
    // pins toward the timer
    output logic trig_pin,
    output logic event_pin
);
    initial begin
        trig_pin = 1'b0;
        event_pin = 1'b0;
    end
    // levels held >= 2 clocks so the two-flop sync never drops one
    task automatic events(input int n, input int hold);
        repeat (n) begin
            @(posedge clk);
            event_pin <= 1'b1;
            repeat (hold) @(posedge clk);
            event_pin <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask
    task automatic trigger();
        @(posedge clk);
        trig_pin <= 1'b1;
        repeat (3) @(posedge clk);
        trig_pin <= 1'b0;
    endtask
endmodule // tmrx_pins

/* File: tmrx_timer.v */
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module tmrx_timer #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RST,
    // register port
    input wire [7:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    // external pins
    input wire TRIG_PIN,
    input wire EVENT_PIN,
    output reg OUT_PIN_ZERO,
    output reg OUT_PIN_ONE,
    // match interrupts
    output reg PERIOD_MATCH_IRQ,
    output reg SECOND_MATCH_IRQ
);

`include "tmrx_map.vh"

localparam ST_IDLE = 2'b00;
localparam ST_WAIT = 2'b01;
localparam ST_RUN = 2'b10;

// ----------------------------------------
// register file
// ----------------------------------------
reg run_enable_q;
reg [2:0] mode_q;
reg event_clock_sel_q;
reg [3:0] edge_sel_q;
reg [CNT_W-1:0] period_compare_q;
reg [CNT_W-1:0] second_compare_q;
reg overflow_q;
reg overflow_d;

wire wr_ctl0 = WR && (ADDR == `TMRX_OFS_CTL0);
wire wr_ctl1 = WR && (ADDR == `TMRX_OFS_CTL1);
wire wr_opt0 = WR && (ADDR == `TMRX_OFS_OPT0);
wire wr_ioc2 = WR && (ADDR == `TMRX_OFS_IOC2);
wire wr_ccr0 = WR && (ADDR == `TMRX_OFS_CCR0);
wire wr_ccr1 = WR && (ADDR == `TMRX_OFS_CCR1);

// software trigger is a write-only strobe, never stored
wire sw_trig = wr_ctl1 && WDATA[`TMRX_CTL1_EST];

function [15:0] zext;
    input [CNT_W-1:0] v;
    begin
        zext = `TMRX_DATA_ZERO;
        zext[CNT_W-1:0] = v;
    end
endfunction

always @(posedge CLK_SYS) begin
    if (RST) begin
        run_enable_q <= 1'b0;
        mode_q <= `TMRX_MODE_INTERVAL;
        event_clock_sel_q <= 1'b0;
        edge_sel_q <= `TMRX_IOC2_RESET;
        period_compare_q <= `TMRX_CCR_RESET;
        second_compare_q <= `TMRX_CCR_RESET;
        overflow_q <= 1'b0;
    end else begin
        if (wr_ctl0) begin
            run_enable_q <= WDATA[`TMRX_CTL0_CE];
        end
        if (wr_ctl1) begin
            mode_q <= WDATA[`TMRX_CTL1_MD_HI:`TMRX_CTL1_MD_LO];
            event_clock_sel_q <= WDATA[`TMRX_CTL1_EEE];
        end
        if (wr_ioc2) begin
            edge_sel_q <= WDATA[`TMRX_IOC2_EES_HI:`TMRX_IOC2_ETS_LO];
        end
        if (wr_ccr0) begin
            period_compare_q <= WDATA[CNT_W-1:0];
        end
        if (wr_ccr1) begin
            second_compare_q <= WDATA[CNT_W-1:0];
        end
        overflow_q <= overflow_d;
    end
end

// ----------------------------------------
// edge detectors on the two input pins
// ----------------------------------------
wire trig_edge;
wire event_edge;

tmrx_edge u_trig_edge (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .PIN(TRIG_PIN),
    .SEL(edge_sel_q[`TMRX_IOC2_ETS_HI:`TMRX_IOC2_ETS_LO]),
    .EDGE(trig_edge)
);

tmrx_edge u_event_edge (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .PIN(EVENT_PIN),
    .SEL(edge_sel_q[`TMRX_IOC2_EES_HI:`TMRX_IOC2_EES_LO]),
    .EDGE(event_edge)
);

// ----------------------------------------
// counter core
// ----------------------------------------
reg [1:0] state_q;
reg [1:0] state_d;
reg [CNT_W-1:0] cnt_q;
reg [CNT_W-1:0] cnt_d;
reg [CNT_W-1:0] buf0_q;
reg [CNT_W-1:0] buf0_d;
reg [CNT_W-1:0] buf1_q;
reg [CNT_W-1:0] buf1_d;
reg out0_d;
reg out1_d;
reg irq0_d;
reg irq1_d;
reg ovf_set;

wire [CNT_W-1:0] cnt_max = {CNT_W{1'b1}};
wire mode_pwm = (mode_q == `TMRX_MODE_TRIGPWM);
wire mode_event = (mode_q == `TMRX_MODE_EVENT);
wire mode_interval = (mode_q == `TMRX_MODE_INTERVAL);
wire trigger = mode_pwm && (trig_edge || sw_trig);

// count clock: pin edges in event mode, or in interval mode with event clock
reg tick;
always @* begin
    if (mode_event) begin
        tick = event_edge;
    end else if (mode_interval && event_clock_sel_q) begin
        tick = event_edge;
    end else begin
        tick = 1'b1;
    end
end

always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    buf0_d = buf0_q;
    buf1_d = buf1_q;
    out0_d = OUT_PIN_ZERO;
    out1_d = OUT_PIN_ONE;
    irq0_d = 1'b0;
    irq1_d = 1'b0;
    overflow_d = overflow_q;
    ovf_set = 1'b0;
    case (state_q)
        ST_IDLE: begin
            cnt_d = cnt_max;
            if (run_enable_q) begin
                if (mode_pwm) begin
                    state_d = ST_WAIT;
                end else begin
                    state_d = ST_RUN;
                    cnt_d = {CNT_W{1'b0}};
                    buf0_d = period_compare_q;
                    buf1_d = second_compare_q;
                    out0_d = ~OUT_PIN_ZERO;
                end
            end
        end
        ST_WAIT: begin
            cnt_d = cnt_max;
            if (!run_enable_q) begin
                state_d = ST_IDLE;
            end else if (trigger) begin
                // FFFFH to zero and counting in one step
                state_d = ST_RUN;
                cnt_d = {CNT_W{1'b0}};
                buf0_d = period_compare_q;
                buf1_d = second_compare_q;
                out1_d = 1'b1;
                out0_d = ~OUT_PIN_ZERO;
            end
        end
        ST_RUN: begin
            if (!run_enable_q) begin
                state_d = ST_IDLE;
                cnt_d = cnt_max;
                out0_d = 1'b0;
                out1_d = 1'b0;
            end else if (trigger) begin
                // a trigger just before a match swallows that match
                cnt_d = {CNT_W{1'b0}};
                out0_d = ~OUT_PIN_ZERO;
                out1_d = 1'b1;
            end else if (tick) begin
                if (cnt_q == buf0_q) begin
                    cnt_d = {CNT_W{1'b0}};
                    irq0_d = 1'b1;
                    if (mode_pwm) begin
                        buf0_d = period_compare_q;
                        buf1_d = second_compare_q;
                        out1_d = 1'b1;
                        out0_d = ~OUT_PIN_ZERO;
                    end else if (mode_interval) begin
                        out0_d = ~OUT_PIN_ZERO;
                    end
                end else begin
                    cnt_d = cnt_q + `TMRX_CNT_ONE;
                    // wrap through FFFFH without a match is an overflow
                    if (cnt_q == cnt_max) begin
                        overflow_d = 1'b1;
                        ovf_set = 1'b1;
                    end
                end
                // other modes raise the second match on the count after equality
                if (!mode_pwm && (cnt_q == buf1_q)) begin
                    irq1_d = 1'b1;
                    if (mode_interval) begin
                        out1_d = ~OUT_PIN_ONE;
                    end
                end
            end
            // pulse mode raises it as the counter lands on the buffer
            if (mode_pwm && run_enable_q && !trigger && (cnt_d == buf1_d)) begin
                irq1_d = 1'b1;
                out1_d = 1'b0;
            end
        end
        default: begin
            state_d = ST_IDLE;
            cnt_d = cnt_max;
        end
    endcase
    // event and interval modes: compare writes bypass the reload point
    if (wr_ccr0 && !mode_pwm) begin
        buf0_d = WDATA[CNT_W-1:0];
    end
    if (wr_ccr1 && !mode_pwm) begin
        buf1_d = WDATA[CNT_W-1:0];
    end
    if (mode_event) begin
        out0_d = 1'b0;
        out1_d = 1'b0;
    end
    // set wins over a software clear in the same cycle
    if (wr_opt0 && !WDATA[`TMRX_OPT0_OVF] && !ovf_set) begin
        overflow_d = 1'b0;
    end
end

always @(posedge CLK_SYS) begin
    if (RST) begin
        state_q <= ST_IDLE;
        cnt_q <= {CNT_W{1'b1}};
        buf0_q <= {CNT_W{1'b0}};
        buf1_q <= {CNT_W{1'b0}};
        OUT_PIN_ZERO <= 1'b0;
        OUT_PIN_ONE <= 1'b0;
        PERIOD_MATCH_IRQ <= 1'b0;
        SECOND_MATCH_IRQ <= 1'b0;
    end else begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        buf0_q <= buf0_d;
        buf1_q <= buf1_d;
        OUT_PIN_ZERO <= out0_d;
        OUT_PIN_ONE <= out1_d;
        PERIOD_MATCH_IRQ <= irq0_d;
        SECOND_MATCH_IRQ <= irq1_d;
    end
end

// ----------------------------------------
// read path
// ----------------------------------------
reg [15:0] rdata_d;

always @* begin
    rdata_d = `TMRX_DATA_ZERO;
    case (ADDR)
        `TMRX_OFS_CTL0: rdata_d[`TMRX_CTL0_CE] = run_enable_q;
        `TMRX_OFS_CTL1: begin
            rdata_d[`TMRX_CTL1_MD_HI:`TMRX_CTL1_MD_LO] = mode_q;
            rdata_d[`TMRX_CTL1_EEE] = event_clock_sel_q;
        end
        `TMRX_OFS_OPT0: rdata_d[`TMRX_OPT0_OVF] = overflow_q;
        `TMRX_OFS_IOC2: rdata_d[`TMRX_IOC2_EES_HI:`TMRX_IOC2_ETS_LO] = edge_sel_q;
        `TMRX_OFS_CCR0: rdata_d = zext(period_compare_q);
        `TMRX_OFS_CCR1: rdata_d = zext(second_compare_q);
        `TMRX_OFS_CNT: rdata_d = zext(cnt_q);
        default: rdata_d = `TMRX_DATA_ZERO;
    endcase
end

always @(posedge CLK_SYS) begin
    if (RST) begin
        RDATA <= `TMRX_DATA_ZERO;
    end else if (RD) begin
        RDATA <= rdata_d;
    end else begin
        RDATA <= `TMRX_DATA_ZERO;
    end
end

endmodule // tmrx_timer

/* File: tmrx_timer_sva.sv */
`timescale 1ns/1ps
module tmrx_timer_sva #(
    parameter CNT_W = 16
) (
    // clock, reset, register port
    input wire CLK_SYS,
    input wire RST,
    input wire [7:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    // pins and interrupts
    input wire OUT_PIN_ZERO,
    input wire OUT_PIN_ONE,
    input wire PERIOD_MATCH_IRQ,
    input wire SECOND_MATCH_IRQ
);
    // ----------------------------------------
    // mode shadow, decoded from bus writes
    // ----------------------------------------
    reg [2:0] mode_q;
    reg run_q;
    always @(posedge CLK_SYS) begin
        if (RST) begin
            mode_q <= 3'h0;
            run_q <= 1'b0;
        end else begin
            if (WR && ADDR == 8'h04)
                mode_q <= WDATA[2:0];
            if (WR && ADDR == 8'h00)
                run_q <= WDATA[0];
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_period_pulse: assert property (PERIOD_MATCH_IRQ |=> !PERIOD_MATCH_IRQ)
        else $error("period match longer than one cycle");
    a_second_pulse: assert property (SECOND_MATCH_IRQ |=> !SECOND_MATCH_IRQ)
        else $error("second match longer than one cycle");
    a_read_quiet: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside read slot");
    a_edge_upper: assert property (RD && ADDR == 8'h0C |=> RDATA[15:4] == 12'h000)
        else $error("edge select upper bits not zero");
    a_event_quiet: assert property (mode_q == 3'h1 |-> !OUT_PIN_ZERO && !OUT_PIN_ONE)
        else $error("pin output in event mode");
    a_stop_quiet: assert property (WR && ADDR == 8'h00 && !WDATA[0] |->
        ##3 (!OUT_PIN_ZERO && !OUT_PIN_ONE) [*4])
        else $error("outputs active after stop");
    a_sw_trig: assert property (mode_q == 3'h2 && WR && ADDR == 8'h04 && WDATA[6]
        && WDATA[2:0] == 3'h2 && run_q && $past(run_q)
        |=> OUT_PIN_ONE && OUT_PIN_ZERO != $past(OUT_PIN_ZERO))
        else $error("software trigger missed outputs");
    a_pwm_wrap: assert property (mode_q == 3'h2 && PERIOD_MATCH_IRQ && !SECOND_MATCH_IRQ
        |-> OUT_PIN_ONE && OUT_PIN_ZERO != $past(OUT_PIN_ZERO))
        else $error("period end without output update");
    a_second_drop: assert property (mode_q == 3'h2 && SECOND_MATCH_IRQ && $past(OUT_PIN_ONE)
        |-> !OUT_PIN_ONE)
        else $error("second match without pulse end");
    cover property (mode_q == 3'h1 && PERIOD_MATCH_IRQ);
    cover property (mode_q == 3'h2 && PERIOD_MATCH_IRQ);
    cover property (mode_q == 3'h2 && SECOND_MATCH_IRQ);
    cover property (mode_q == 3'h0 && PERIOD_MATCH_IRQ);
endmodule // tmrx_timer_sva

bind tmrx_timer tmrx_timer_sva #(.CNT_W(CNT_W)) i_tmrx_timer_sva (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .OUT_PIN_ZERO(OUT_PIN_ZERO), .OUT_PIN_ONE(OUT_PIN_ONE),
    .PERIOD_MATCH_IRQ(PERIOD_MATCH_IRQ), .SECOND_MATCH_IRQ(SECOND_MATCH_IRQ));
